// ===== rtl/dtf_delay_timer.sv
// delay timer top: trigger edges, mode state machine, elapsed time
`timescale 1ns/1ns
`default_nettype none

module dtf_delay_timer #(
   parameter int P_CYC_10MS = dtf_pkg::CYC_10MS
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic TRIG_I,
   input wire logic CLEAR_I,
   input wire logic [1:0] MODE_I,
   input wire logic [7:0] RETAIN_CODE_I,
   input wire logic POWER_UP_I,
   input wire logic RISE_FROM_REF_I,
   input wire logic [dtf_pkg::FIELD_W-1:0] RISE_HI_I,
   input wire logic [dtf_pkg::FIELD_W-1:0] RISE_LO_I,
   input wire logic [1:0] RISE_BASE_I,
   input wire logic [dtf_pkg::BLK_W-1:0] RISE_BLOCK_I,
   input wire logic signed [dtf_pkg::ACT_W-1:0] RISE_ACT_I,
   input wire logic FALL_FROM_REF_I,
   input wire logic [dtf_pkg::FIELD_W-1:0] FALL_HI_I,
   input wire logic [dtf_pkg::FIELD_W-1:0] FALL_LO_I,
   input wire logic [1:0] FALL_BASE_I,
   input wire logic [dtf_pkg::BLK_W-1:0] FALL_BLOCK_I,
   input wire logic signed [dtf_pkg::ACT_W-1:0] FALL_ACT_I,
   output logic Q_O,
   output logic [dtf_pkg::TIME_W-1:0] ELAPSED_O,
   output logic TIMING_O,
   output logic RETAINED_O,
   output logic [dtf_pkg::BLK_W-1:0] RISE_BLOCK_O,
   output logic [dtf_pkg::BLK_W-1:0] FALL_BLOCK_O
);
   import dtf_pkg::*;

   dtf_state_t state;
   dtf_state_t next_state;
   logic [1:0] mode;
   logic trig_q;
   logic rise_edge;
   logic fall_edge;
   logic retain;
   logic pwr_clear;
   logic [2:0] tick;
   logic [3:0] tick_all;
   logic [TIME_W-1:0] rise_ticks;
   logic [TIME_W-1:0] fall_ticks;
   logic [1:0] rise_base;
   logic [1:0] fall_base;
   logic tick_now;
   logic [TIME_W-1:0] preset_now;
   logic [TIME_W-1:0] elapsed;
   logic [TIME_W-1:0] elapsed_inc;
   logic hit;
   logic timing_now;
   logic next_timing;
   logic q;

   // ****************************************
   // mode decode
   // ****************************************
   // the unused code behaves as a plain on-delay
   always_comb begin
      unique case (MODE_I)
         MODE_ON_DELAY: begin
            mode = MODE_ON_DELAY;
         end
         MODE_OFF_DELAY: begin
            mode = MODE_OFF_DELAY;
         end
         MODE_ON_OFF: begin
            mode = MODE_ON_OFF;
         end
         default: begin
            mode = MODE_ON_DELAY;
         end
      endcase
   end

   // ****************************************
   // retention and power recovery
   // ****************************************
   // any other code keeps the last valid setting
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         retain <= 1'b0;
      end else if (RETAIN_CODE_I == RETAIN_CODE_ON) begin
         retain <= 1'b1; // [RULE6]
      end else if (RETAIN_CODE_I == RETAIN_CODE_OFF) begin
         retain <= 1'b0; // [RULE6]
      end
   end

   assign pwr_clear = POWER_UP_I && !retain; // [RULE5]

   // ****************************************
   // trigger edges
   // ****************************************
   // cleared on a non-retentive recovery so a held trigger is new
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || pwr_clear) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= TRIG_I;
      end
   end

   assign rise_edge = TRIG_I && !trig_q;
   assign fall_edge = !TRIG_I && trig_q;

   // ****************************************
   // presets and referenced blocks
   // ****************************************
   dtf_preset u_rise_preset (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .from_ref_i(RISE_FROM_REF_I),
      .hi_i(RISE_HI_I),
      .lo_i(RISE_LO_I),
      .base_i(RISE_BASE_I),
      .act_i(RISE_ACT_I),
      .ticks_o(rise_ticks),
      .base_o(rise_base)
   );

   dtf_preset u_fall_preset (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .from_ref_i(FALL_FROM_REF_I),
      .hi_i(FALL_HI_I),
      .lo_i(FALL_LO_I),
      .base_i(FALL_BASE_I),
      .act_i(FALL_ACT_I),
      .ticks_o(fall_ticks),
      .base_o(fall_base)
   );

   // block number requested from the surrounding program
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         RISE_BLOCK_O <= BLK_NONE;
         FALL_BLOCK_O <= BLK_NONE;
      end else begin
         RISE_BLOCK_O <= RISE_FROM_REF_I ? RISE_BLOCK_I : BLK_NONE; // [RULE10]
         FALL_BLOCK_O <= FALL_FROM_REF_I ? FALL_BLOCK_I : BLK_NONE; // [RULE10]
      end
   end

   // ****************************************
   // timebase ticks and comparison
   // ****************************************
   dtf_prescale #(
      .P_CYC_10MS(P_CYC_10MS)
   ) u_prescale (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .tick_o(tick)
   );

   assign tick_all = {1'b0, tick};
   assign timing_now = (state == ST_RISE) || (state == ST_FALL);
   assign preset_now = (state == ST_FALL) ? fall_ticks : rise_ticks;
   assign elapsed_inc = elapsed + 14'h0001;

   always_comb begin
      if (state == ST_FALL) begin
         tick_now = tick_all[fall_base]; // [RULE20]
      end else begin
         tick_now = tick_all[rise_base]; // [RULE20]
      end
   end

   // a preset lowered under a running time still expires at the next tick
   assign hit = timing_now && tick_now && (elapsed_inc >= preset_now); // [RULE20]

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (rise_edge) begin
               if (mode == MODE_OFF_DELAY) begin
                  next_state = ST_HIGH; // [RULE11]
               end else begin
                  next_state = ST_RISE; // [RULE1] [RULE15]
               end
            end
         end
         ST_RISE: begin
            if (!TRIG_I) begin
               next_state = ST_IDLE; // [RULE3] [RULE18]
            end else if (hit) begin
               next_state = ST_HIGH; // [RULE2] [RULE16]
            end
         end
         ST_HIGH: begin
            if (mode == MODE_ON_DELAY) begin
               if (!TRIG_I) begin
                  next_state = ST_IDLE; // [RULE4]
               end
            end else if (fall_edge) begin
               next_state = ST_FALL; // [RULE12] [RULE15]
            end
         end
         ST_FALL: begin
            if (TRIG_I) begin
               next_state = ST_HIGH; // [RULE13] [RULE19]
            end else if (hit) begin
               next_state = ST_IDLE; // [RULE12] [RULE17]
            end
         end
      endcase
      if (mode == MODE_OFF_DELAY && CLEAR_I) begin
         next_state = ST_IDLE; // [RULE14]
      end
   end

   assign next_timing = (next_state == ST_RISE) || (next_state == ST_FALL);

   // ****************************************
   // state, elapsed time and output
   // ****************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || pwr_clear) begin
         state <= ST_IDLE; // [RULE5]
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || pwr_clear) begin
         elapsed <= ELAPSED_RESET; // [RULE5]
      end else if (next_state == ST_IDLE) begin
         elapsed <= ELAPSED_RESET; // [RULE3] [RULE14]
      end else if (next_timing && next_state != state) begin
         elapsed <= ELAPSED_RESET; // [RULE1] [RULE12] [RULE13]
      end else if (hit) begin
         elapsed <= preset_now; // [RULE2]
      end else if (timing_now && tick_now) begin
         elapsed <= elapsed_inc; // [RULE20]
      end
   end

   // output high in the held state and through the fall delay
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || pwr_clear) begin
         q <= 1'b0; // [RULE5]
      end else begin
         q <= (next_state == ST_HIGH) || (next_state == ST_FALL); // [RULE17]
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || pwr_clear) begin
         TIMING_O <= 1'b0;
      end else begin
         TIMING_O <= next_timing;
      end
   end

   assign Q_O = q;
   assign ELAPSED_O = elapsed;
   assign RETAINED_O = retain;
endmodule : dtf_delay_timer

`default_nettype wire

// ===== rtl/dtf_pkg.sv
// constants, codes and types shared by the delay timer files
//
// How it works
// (RULE1) on-delay: rising trigger restarts elapsed time
// (RULE2) on-delay: output rises when elapsed reaches preset
// (RULE3) on-delay: early trigger drop clears elapsed time
// (RULE4) on-delay: output low whenever trigger low
// (RULE5) power recovery clears state unless retentive
// (RULE6) retention codes: slash off, letter R on
// (RULE7) direct presets: seconds, minutes, hours timebases
// (RULE8) referenced presets: count in chosen timebase; the 10 ms base takes ms and divides by 10
// (RULE9) out of range references clamp to limits
// (RULE10) any preset may come from another block
// (RULE11) off-delay: output rises at once with trigger
// (RULE12) off-delay: falling trigger restarts timing, then expires
// (RULE13) off-delay: each new pulse restarts the timing
// (RULE14) off-delay: clear input ends timing and output
// (RULE15) on/off: rising starts rise delay, falling fall
// (RULE16) on/off: set output after rise delay, trigger high
// (RULE17) on/off: clear output after fall delay expires
// (RULE18) on/off: trigger drop abandons rise delay
// (RULE19) on/off: trigger rise abandons fall delay
// (RULE20) prescaled ticks advance elapsed time, compared each tick

package dtf_pkg;
   // ****************************************
   // clock and timebase
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_MS = 10;
   localparam int CYC_10MS = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [6:0] SUB_1S_LAST = 7'h63;
   localparam logic [5:0] SUB_1MIN_LAST = 6'h3B;

   // ****************************************
   // widths and limits
   // ****************************************
   localparam int TIME_W = 14;
   localparam int FIELD_W = 7;
   localparam int BLK_W = 8;
   localparam int ACT_W = 32;
   localparam int REF_W = 17;
   localparam logic [6:0] PAR_HI_MAX = 7'h63;
   localparam logic [6:0] PAR_LO_S_MAX = 7'h63;
   localparam logic [6:0] PAR_LO_MH_MAX = 7'h3B;
   localparam logic [13:0] PAR_S_MUL = 14'h0064;
   localparam logic [13:0] PAR_MH_MUL = 14'h003C;
   localparam logic [16:0] REF_MS_MAX = 17'h1_869E;
   localparam logic [16:0] REF_MS_DIV = 17'h0_000A;
   localparam logic [16:0] REF_SM_MAX = 17'h0_176F;

   // ****************************************
   // codes and reset values
   // ****************************************
   localparam logic [7:0] RETAIN_CODE_OFF = 8'h2F;
   localparam logic [7:0] RETAIN_CODE_ON = 8'h52;
   localparam logic [1:0] BASE_BAD = 2'h3;
   localparam logic [13:0] ELAPSED_RESET = 14'h0000;
   localparam logic [7:0] BLK_NONE = 8'h00;

   typedef enum logic [1:0] {
      MODE_ON_DELAY = 2'h0,
      MODE_OFF_DELAY = 2'h1,
      MODE_ON_OFF = 2'h2
   } dtf_mode_t;

   typedef enum logic [1:0] {
      BASE_10MS = 2'h0,
      BASE_1S = 2'h1,
      BASE_1MIN = 2'h2
   } dtf_base_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RISE = 2'h1,
      ST_HIGH = 2'h3,
      ST_FALL = 2'h2
   } dtf_state_t;
endpackage : dtf_pkg

// ===== rtl/dtf_prescale.sv
// timebase prescaler: 10 ms, 1 s and 1 min tick pulses
`timescale 1ns/1ns
`default_nettype none

module dtf_prescale #(
   parameter int P_CYC_10MS = dtf_pkg::CYC_10MS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic [2:0] tick_o
);
   import dtf_pkg::*;

   localparam int CW = $clog2(P_CYC_10MS + 1);
   localparam logic [CW-1:0] BASE_LAST = CW'(P_CYC_10MS - 1);

   logic [CW-1:0] base_cnt;
   logic [6:0] sec_cnt;
   logic [5:0] min_cnt;
   logic t10;
   logic t1s;
   logic t1m;

   assign t10 = (base_cnt == BASE_LAST);
   assign t1s = t10 && (sec_cnt == SUB_1S_LAST);
   assign t1m = t1s && (min_cnt == SUB_1MIN_LAST);

   // free running: timing starts at any phase, so one tick of jitter
   always_ff @(posedge clk_i) begin
      if (rst_i || t10) begin
         base_cnt <= '0;
      end else begin
         base_cnt <= base_cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || t1s) begin
         sec_cnt <= '0;
      end else if (t10) begin
         sec_cnt <= sec_cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || t1m) begin
         min_cnt <= '0;
      end else if (t1s) begin
         min_cnt <= min_cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_o <= '0;
      end else begin
         tick_o <= {t1m, t1s, t10}; // [RULE20]
      end
   end
endmodule : dtf_prescale

`default_nettype wire

// ===== rtl/dtf_preset.sv
// preset conversion: direct fields or a referenced value to ticks
`timescale 1ns/1ns
`default_nettype none

module dtf_preset (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic from_ref_i,
   input wire logic [dtf_pkg::FIELD_W-1:0] hi_i,
   input wire logic [dtf_pkg::FIELD_W-1:0] lo_i,
   input wire logic [1:0] base_i,
   input wire logic signed [dtf_pkg::ACT_W-1:0] act_i,
   output logic [dtf_pkg::TIME_W-1:0] ticks_o,
   output logic [1:0] base_o
);
   import dtf_pkg::*;

   logic [1:0] base_n;
   logic [FIELD_W-1:0] hi_c;
   logic [FIELD_W-1:0] lo_c;
   logic [FIELD_W-1:0] lo_max;
   logic [TIME_W-1:0] mul;
   logic [TIME_W-1:0] par_ticks;
   logic [TIME_W-1:0] ref_ticks;
   logic [REF_W-1:0] raw;
   logic [REF_W-1:0] ref_ms;
   logic [REF_W-1:0] ref_sm;

   always_comb begin
      base_n = (base_i == BASE_BAD) ? BASE_10MS : base_i;
      // seconds show ss:hh, minutes and hours show two:sixty fields
      hi_c = (hi_i > PAR_HI_MAX) ? PAR_HI_MAX : hi_i; // [RULE7]
      lo_max = (base_n == BASE_10MS) ? PAR_LO_S_MAX : PAR_LO_MH_MAX;
      lo_c = (lo_i > lo_max) ? lo_max : lo_i; // [RULE7]
      mul = (base_n == BASE_10MS) ? PAR_S_MUL : PAR_MH_MUL;
      par_ticks = ({7'h00, hi_c} * mul) + {7'h00, lo_c}; // [RULE7]
      // negatives go to zero, anything huge to the top limit
      if (act_i[ACT_W-1]) begin
         raw = '0; // [RULE9]
      end else if (|act_i[ACT_W-2:REF_W]) begin
         raw = '1; // [RULE9]
      end else begin
         raw = act_i[REF_W-1:0];
      end
      ref_ms = (raw > REF_MS_MAX) ? REF_MS_MAX : raw; // [RULE9]
      ref_sm = (raw > REF_SM_MAX) ? REF_SM_MAX : raw; // [RULE9]
      if (base_n == BASE_10MS) begin
         ref_ticks = TIME_W'(ref_ms / REF_MS_DIV); // [RULE8]
      end else begin
         ref_ticks = ref_sm[TIME_W-1:0]; // [RULE8]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ticks_o <= ELAPSED_RESET;
         base_o <= BASE_10MS;
      end else begin
         ticks_o <= from_ref_i ? ref_ticks : par_ticks; // [RULE10]
         base_o <= base_n;
      end
   end
endmodule : dtf_preset

`default_nettype wire

// ===== test/dtf_delay_timer_asserts.sv
// concurrent checks on the delay timer top ports
`timescale 1ns/1ns
`default_nettype none

module dtf_delay_timer_asserts (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic TRIG_I,
   input wire logic CLEAR_I,
   input wire logic [1:0] MODE_I,
   input wire logic POWER_UP_I,
   input wire logic RISE_FROM_REF_I,
   input wire logic [dtf_pkg::BLK_W-1:0] RISE_BLOCK_I,
   input wire logic Q_O,
   input wire logic [dtf_pkg::TIME_W-1:0] ELAPSED_O,
   input wire logic TIMING_O,
   input wire logic RETAINED_O,
   input wire logic [dtf_pkg::BLK_W-1:0] RISE_BLOCK_O
);
   import dtf_pkg::*;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);

   // ****************************************
   // properties
   // ****************************************
   property p_on_start;
      (MODE_I == 2'h0 && $rose(TRIG_I)) |=>
         TIMING_O && ELAPSED_O == ELAPSED_RESET;
   endproperty
   a_on_start: assert property (p_on_start)
      else $error("on-delay did not start timing from zero");
   property p_on_low;
      (MODE_I == 2'h0 && !TRIG_I) |=> !Q_O && ELAPSED_O == ELAPSED_RESET;
   endproperty
   a_on_low: assert property (p_on_low)
      else $error("on-delay output or elapsed set with trigger low");
   property p_off_set;
      (MODE_I == 2'h1 && $rose(TRIG_I) && !CLEAR_I) |=> Q_O;
   endproperty
   a_off_set: assert property (p_off_set)
      else $error("off-delay output did not follow trigger");
   property p_off_fall;
      (MODE_I == 2'h1 && $fell(TRIG_I) && Q_O && !CLEAR_I) |=>
         Q_O && TIMING_O && ELAPSED_O == ELAPSED_RESET;
   endproperty
   a_off_fall: assert property (p_off_fall)
      else $error("off-delay did not restart on falling trigger");
   property p_off_clr;
      (MODE_I == 2'h1 && CLEAR_I) |=>
         !Q_O && !TIMING_O && ELAPSED_O == ELAPSED_RESET;
   endproperty
   a_off_clr: assert property (p_off_clr)
      else $error("clear did not end off-delay");
   property p_oo_rise;
      (MODE_I == 2'h2 && !Q_O && $fell(TRIG_I)) |=> !Q_O && !TIMING_O;
   endproperty
   a_oo_rise: assert property (p_oo_rise)
      else $error("rise delay kept running after trigger drop");
   property p_oo_fall;
      (MODE_I == 2'h2 && Q_O && $rose(TRIG_I)) |=> Q_O && !TIMING_O;
   endproperty
   a_oo_fall: assert property (p_oo_fall)
      else $error("fall delay kept running after trigger rise");
   property p_pwr;
      (POWER_UP_I && !RETAINED_O) |=>
         !Q_O && !TIMING_O && ELAPSED_O == ELAPSED_RESET;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("state survived power recovery without retention");
   property p_blk;
      RISE_FROM_REF_I |=> RISE_BLOCK_O == $past(RISE_BLOCK_I);
   endproperty
   a_blk: assert property (p_blk)
      else $error("referenced block number not shown");

   // ****************************************
   // covers
   // ****************************************
   c_on: cover property (MODE_I == 2'h0 && $rose(Q_O));
   c_oo: cover property (MODE_I == 2'h2 && $fell(Q_O));
   c_ret: cover property (POWER_UP_I && RETAINED_O && Q_O);
endmodule : dtf_delay_timer_asserts
`default_nettype wire

// ===== test/dtf_delay_timer_tb_top.sv
// self-checking bench for the delay timer top
`timescale 1ns/1ns
`default_nettype none

module dtf_delay_timer_tb_top;
   logic clk = 1'b0, rst = 1'b1, trig = 1'b0, clr = 1'b0, pwr = 1'b0;
   logic rref = 1'b0, fref = 1'b0, q, tmg, ret;
   logic [1:0] mode = 2'h0, rbase = 2'h0, fbase = 2'h0;
   logic [7:0] code = 8'h2F, rblk = 8'h06, fblk = 8'h00, rblk_o, fblk_o;
   logic [6:0] rhi = 7'h00, rlo = 7'h03, fhi = 7'h00, flo = 7'h05;
   logic signed [31:0] ract = 32'sh0000_001E, fact = 32'sh0000_0000;
   logic [13:0] el;
   int err_count = 0, check_count = 0, cycles = 0;

   // short prescale: one 10 ms tick every 4 cycles
   dtf_delay_timer #(.P_CYC_10MS(4)) dut_u (
      .REF_CLK_I(clk), .RST_I(rst), .TRIG_I(trig), .CLEAR_I(clr),
      .MODE_I(mode), .RETAIN_CODE_I(code), .POWER_UP_I(pwr),
      .RISE_FROM_REF_I(rref), .RISE_HI_I(rhi), .RISE_LO_I(rlo),
      .RISE_BASE_I(rbase), .RISE_BLOCK_I(rblk), .RISE_ACT_I(ract),
      .FALL_FROM_REF_I(fref), .FALL_HI_I(fhi), .FALL_LO_I(flo),
      .FALL_BASE_I(fbase), .FALL_BLOCK_I(fblk), .FALL_ACT_I(fact),
      .Q_O(q), .ELAPSED_O(el), .TIMING_O(tmg), .RETAINED_O(ret),
      .RISE_BLOCK_O(rblk_o), .FALL_BLOCK_O(fblk_o));

   always #2 clk = ~clk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   // ceiling covers the two-minute and one-minute slow waits plus margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic ck1(input string what, input logic seen, exp);
      check(what, {15'h0000, seen}, {15'h0000, exp});
   endtask : ck1

   task automatic trg(input logic v);
      trig = v;
      cyc(1);
   endtask : trg

   task automatic pwr_pulse();
      pwr = 1'b1;
      cyc(1);
      pwr = 1'b0;
   endtask : pwr_pulse

   task automatic wait_q(input logic v, input int lim, output int n);
      n = 0;
      while (q !== v && n < lim) begin
         cyc(1);
         n++;
      end
      ck1("q wait", q, v);
   endtask : wait_q

   task automatic run_on(input logic [15:0] exp, input int lo, hi);
      int n;
      trg(1'b1);
      wait_q(1'b1, hi + 8, n);
      ck1("on time", n >= lo && n <= hi, 1'b1);
      check("elapsed", {2'h0, el}, exp);
      trg(1'b0);
      cyc(2);
   endtask : run_on

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_on();
      int n;
      mode = 2'h0;
      trg(1'b1);
      ck1("timing", tmg, 1'b1);
      check("elapsed", {2'h0, el}, 16'h0000);
      wait_q(1'b1, 40, n);
      ck1("on time", n >= 8 && n <= 16, 1'b1);
      check("elapsed", {2'h0, el}, 16'h0003);
      trg(1'b0);
      ck1("q", q, 1'b0);
      check("elapsed", {2'h0, el}, 16'h0000);
      trg(1'b1);
      cyc(5);
      trg(1'b0);
      check("elapsed", {2'h0, el}, 16'h0000);
      trg(1'b1);
      cyc(7);
      ck1("q", q, 1'b0);
      trg(1'b0);
      // spare mode and base codes fall back to on-delay and 10 ms
      mode = 2'h3;
      rbase = 2'h3;
      cyc(2);
      run_on(16'h0003, 8, 16);
      rbase = 2'h0;
   endtask : t_on

   task automatic t_off();
      int n;
      mode = 2'h1;
      trg(1'b1);
      ck1("q", q, 1'b1);
      trg(1'b0);
      ck1("q", q, 1'b1);
      ck1("timing", tmg, 1'b1);
      cyc(12);
      trg(1'b1);
      trg(1'b0);
      check("elapsed", {2'h0, el}, 16'h0000);
      wait_q(1'b0, 60, n);
      ck1("off time", n >= 16 && n <= 24, 1'b1);
      trg(1'b1);
      trg(1'b0);
      cyc(4);
      clr = 1'b1;
      cyc(1);
      ck1("q", q, 1'b0);
      ck1("timing", tmg, 1'b0);
      check("elapsed", {2'h0, el}, 16'h0000);
      clr = 1'b0;
      cyc(1);
      // referenced fall preset: 20 ms is two ticks
      fref = 1'b1;
      fblk = 8'h0B;
      fact = 32'sh0000_0014;
      cyc(2);
      check("block", {8'h00, fblk_o}, 16'h000B);
      trg(1'b1);
      trg(1'b0);
      wait_q(1'b0, 20, n);
      ck1("off time", n >= 4 && n <= 8, 1'b1);
      check("elapsed", {2'h0, el}, 16'h0000);
      fref = 1'b0;
      cyc(1);
   endtask : t_off

   task automatic t_onoff();
      int n;
      mode = 2'h2;
      trg(1'b1);
      wait_q(1'b1, 40, n);
      trg(1'b0);
      ck1("q", q, 1'b1);
      ck1("timing", tmg, 1'b1);
      cyc(8);
      trg(1'b1);
      ck1("q", q, 1'b1);
      ck1("timing", tmg, 1'b0);
      trg(1'b0);
      wait_q(1'b0, 60, n);
      ck1("off time", n >= 16 && n <= 24, 1'b1);
      trg(1'b1);
      cyc(3);
      trg(1'b0);
      ck1("timing", tmg, 1'b0);
      cyc(16);
      ck1("q", q, 1'b0);
   endtask : t_onoff

   task automatic t_retain();
      int n;
      code = 8'h52;
      cyc(1);
      ck1("retained", ret, 1'b1);
      code = 8'h41;
      mode = 2'h0;
      trg(1'b1);
      ck1("retained", ret, 1'b1);
      wait_q(1'b1, 40, n);
      pwr_pulse();
      ck1("q", q, 1'b1);
      check("elapsed", {2'h0, el}, 16'h0003);
      code = 8'h2F;
      cyc(1);
      ck1("retained", ret, 1'b0);
      pwr_pulse();
      ck1("q", q, 1'b0);
      check("elapsed", {2'h0, el}, 16'h0000);
      trg(1'b0);
      cyc(2);
   endtask : t_retain

   task automatic t_ref();
      int p;
      rhi = 7'h01;
      rlo = 7'h00;
      cyc(2);
      run_on(16'h0064, 396, 408);
      // low field above 99 is held at 99
      rhi = 7'h00;
      rlo = 7'h7F;
      cyc(2);
      run_on(16'h0063, 392, 404);
      rref = 1'b1;
      cyc(2);
      check("block", {8'h00, rblk_o}, 16'h0006);
      run_on(16'h0003, 8, 16);
      ract = 32'shFFFF_FFFB;
      cyc(2);
      run_on(16'h0000, 0, 8);
      ract = 32'sh0000_0001;
      rhi = 7'h00;
      rlo = 7'h02;
      // slow bases: one tick is 400 or 24000 cycles here
      for (int r = 0; r < 2; r++) begin
         for (int i = 1; i < 3; i++) begin
            rref = r[0];
            rbase = i[1:0];
            p = (i == 1) ? 400 : 24000;
            cyc(2);
            run_on(16'(2 - r), p * (1 - r), p * (2 - r) + 4);
         end
      end
      rref = 1'b0;
      cyc(2);
      check("block", {8'h00, rblk_o}, 16'h0000);
      check("block", {8'h00, fblk_o}, 16'h0000);
   endtask : t_ref

   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(2);
      t_on();
      t_off();
      t_onoff();
      t_retain();
      t_ref();
      complete_run();
   end
endmodule : dtf_delay_timer_tb_top

bind dtf_delay_timer dtf_delay_timer_asserts chk_u (
   .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .TRIG_I(TRIG_I),
   .CLEAR_I(CLEAR_I), .MODE_I(MODE_I), .POWER_UP_I(POWER_UP_I),
   .RISE_FROM_REF_I(RISE_FROM_REF_I), .RISE_BLOCK_I(RISE_BLOCK_I),
   .Q_O(Q_O), .ELAPSED_O(ELAPSED_O), .TIMING_O(TIMING_O),
   .RETAINED_O(RETAINED_O), .RISE_BLOCK_O(RISE_BLOCK_O));
`default_nettype wire
